/* File: rtl/dlv_pkg.sv */
// shared constants for the drive-level port block
package dlv_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] DLV_DRIVE_LEVEL_OFFS = 8'h10;
  localparam logic [7:0] DLV_CLEAR_OFFS = 8'h14;
  localparam logic [7:0] DLV_SET_OFFS = 8'h18;
  localparam logic [7:0] DLV_TOGGLE_OFFS = 8'h1c;
  localparam logic [7:0] DLV_DIR_OFFS = 8'h00;
  localparam logic [7:0] DLV_PULL_OFFS = 8'h04;
  localparam logic [7:0] DLV_PROT_OFFS = 8'h08;
  // ==========================================
  // reset values and bus answers
  localparam logic [31:0] DLV_DRIVE_LEVEL_RST = 32'h0000_0000;
  localparam logic [31:0] DLV_DIR_RST = 32'h0000_0000;
  localparam logic [31:0] DLV_PULL_RST = 32'h0000_0000;
  localparam logic [1:0] DLV_RESP_OKAY = 2'h0;
  localparam logic [1:0] DLV_RESP_SLVERR = 2'h2;
  localparam int DLV_PROT_BIT = 0;
  // ==========================================
  // drive-level write operations, direct and alias
  typedef enum logic [1:0] {
    DLV_OP_WRITE,
    DLV_OP_CLEAR,
    DLV_OP_SET,
    DLV_OP_TOGGLE
  } dlv_op_e;
endpackage

/* File: rtl/dlv_wr_if.sv */
// carrier between the bus slave and the drive-level logic
`timescale 1ns/1ps
interface dlv_wr_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb, input wr_ok);
  modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, output wr_ok);
endinterface

/* File: rtl/dlv_axi_slave.sv */
// axi4-lite slave front end, write channels only
`timescale 1ns/1ps
module dlv_axi_slave
  import dlv_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  dlv_wr_if.slave wr
);
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic fire;

  assign awready_o = !aw_held_reg && !bvalid_o;
  assign wready_o = !w_held_reg && !bvalid_o;
  assign fire = aw_held_reg && w_held_reg && !bvalid_o;
  assign wr.wr_en = fire;
  assign wr.wr_addr = awaddr_reg;
  assign wr.wr_data = wdata_reg;
  assign wr.wr_strb = wstrb_reg;

  // ==========================================
  // address and data capture, either order
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr_i;
      end else if (fire) begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata_i;
        wstrb_reg <= wstrb_i;
      end else if (fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // write response
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bvalid_o <= 1'b0;
      bresp_o <= DLV_RESP_OKAY;
    end else if (fire) begin
      bvalid_o <= 1'b1;
      bresp_o <= wr.wr_ok ? DLV_RESP_OKAY : DLV_RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end
endmodule // dlv_axi_slave

/* File: rtl/dlv_port_out.sv */
// drive-level register with clear, set and toggle aliases
// What this block does
// - output pins drive low on level bit 0, high on 1
// - pulled input pins get pull-down on level 0, pull-up on 1
// - clear alias write clears every level bit written as 1
// - set alias write sets every level bit written as 1
// - toggle alias write inverts every level bit written as 1
// - alias bits written as 0 leave level bits unchanged
// - level register and all three aliases read the current level
// - one alias write updates all selected bits at once
// - direction bit 1 means output, 0 means input
`timescale 1ns/1ps
module dlv_port_out
  import dlv_pkg::*;
#(
  parameter int PINS = 32
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [PINS-1:0] pin_o,
  output logic [PINS-1:0] pin_oe_o,
  output logic [PINS-1:0] pull_up_o,
  output logic [PINS-1:0] pull_down_o
);
  if (PINS < 1 || PINS > 32) begin : g_pins_check
    $error("PINS must be 1 to 32");
  end

  dlv_wr_if wr ();

  logic [PINS-1:0] drive_level_reg;
  logic [PINS-1:0] drive_level_next;
  logic [PINS-1:0] direction_reg;
  logic [PINS-1:0] pull_enable_reg;
  logic protect_reg;
  logic [31:0] wmask;
  logic [PINS-1:0] wbits;
  logic level_hit;
  dlv_op_e op;

  dlv_axi_slave u_slave (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .awaddr_i(s_axi_awaddr_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .bresp_o(s_axi_bresp_o),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .wr(wr.slave)
  );

  // ==========================================
  // write decode
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic is_level(input logic [7:0] a);
    is_level = (a == DLV_DRIVE_LEVEL_OFFS) || (a == DLV_CLEAR_OFFS) ||
      (a == DLV_SET_OFFS) || (a == DLV_TOGGLE_OFFS);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_level(a) || (a == DLV_DIR_OFFS) || (a == DLV_PULL_OFFS) || (a == DLV_PROT_OFFS);
  endfunction

  assign wmask = strb_mask(wr.wr_strb);
  assign wbits = PINS'(wr.wr_data & wmask);
  assign level_hit = wr.wr_en && is_level(wr.wr_addr);
  assign wr.wr_ok = is_mapped(wr.wr_addr) && !(protect_reg && is_level(wr.wr_addr));

  always_comb begin
    case (wr.wr_addr)
      DLV_CLEAR_OFFS: op = DLV_OP_CLEAR;
      DLV_SET_OFFS: op = DLV_OP_SET;
      DLV_TOGGLE_OFFS: op = DLV_OP_TOGGLE;
      default: op = DLV_OP_WRITE;
    endcase
  end

  // ==========================================
  // drive-level next value
  always_comb begin
    drive_level_next = drive_level_reg;
    if (level_hit && !protect_reg) begin
      case (op)
        DLV_OP_CLEAR: drive_level_next = drive_level_reg & ~wbits;
        DLV_OP_SET: drive_level_next = drive_level_reg | wbits;
        DLV_OP_TOGGLE: drive_level_next = drive_level_reg ^ wbits;
        default: drive_level_next = (drive_level_reg & ~PINS'(wmask)) | wbits;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      drive_level_reg <= DLV_DRIVE_LEVEL_RST[PINS-1:0];
    end else begin
      drive_level_reg <= drive_level_next;
    end
  end

  // ==========================================
  // direction, pull enable and protection
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      direction_reg <= DLV_DIR_RST[PINS-1:0];
      pull_enable_reg <= DLV_PULL_RST[PINS-1:0];
      protect_reg <= 1'b0;
    end else if (wr.wr_en) begin
      if (wr.wr_addr == DLV_DIR_OFFS) begin
        direction_reg <= (direction_reg & ~PINS'(wmask)) | wbits;
      end
      if (wr.wr_addr == DLV_PULL_OFFS) begin
        pull_enable_reg <= (pull_enable_reg & ~PINS'(wmask)) | wbits;
      end
      if (wr.wr_addr == DLV_PROT_OFFS && wr.wr_strb[0]) begin
        protect_reg <= wr.wr_data[DLV_PROT_BIT];
      end
    end
  end

  // ==========================================
  // pin drivers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pin_o <= '0;
      pin_oe_o <= '0;
      pull_up_o <= '0;
      pull_down_o <= '0;
    end else begin
      pin_o <= drive_level_next & direction_reg;
      pin_oe_o <= direction_reg;
      pull_up_o <= ~direction_reg & pull_enable_reg & drive_level_next;
      pull_down_o <= ~direction_reg & pull_enable_reg & ~drive_level_next;
    end
  end

  // ==========================================
  // read channel
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= DLV_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= is_mapped(s_axi_araddr_i) ? DLV_RESP_OKAY : DLV_RESP_SLVERR;
      if (is_level(s_axi_araddr_i)) begin
        s_axi_rdata_o <= 32'(drive_level_reg);
      end else if (s_axi_araddr_i == DLV_DIR_OFFS) begin
        s_axi_rdata_o <= 32'(direction_reg);
      end else if (s_axi_araddr_i == DLV_PULL_OFFS) begin
        s_axi_rdata_o <= 32'(pull_enable_reg);
      end else if (s_axi_araddr_i == DLV_PROT_OFFS) begin
        s_axi_rdata_o <= 32'(protect_reg);
      end else begin
        s_axi_rdata_o <= 32'h0000_0000;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ==========================================
  // checks
  sequence s_alias_write(logic [7:0] a);
    wr.wr_en && wr.wr_addr == a && !protect_reg && wr.wr_strb == 4'hf;
  endsequence

  property p_clear;
    @(posedge sys_clk_i) disable iff (srst_i)
      s_alias_write(DLV_CLEAR_OFFS) |=> drive_level_reg == ($past(drive_level_reg) & ~$past(wbits));
  endproperty
  a_clear: assert property (p_clear) else $error("clear alias wrong");

  property p_set;
    @(posedge sys_clk_i) disable iff (srst_i)
      s_alias_write(DLV_SET_OFFS) |=> drive_level_reg == ($past(drive_level_reg) | $past(wbits));
  endproperty
  a_set: assert property (p_set) else $error("set alias wrong");

  property p_toggle;
    @(posedge sys_clk_i) disable iff (srst_i)
      s_alias_write(DLV_TOGGLE_OFFS) |=> drive_level_reg == ($past(drive_level_reg) ^ $past(wbits));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle alias wrong");

  property p_zero_keep;
    @(posedge sys_clk_i) disable iff (srst_i)
      (level_hit && op != DLV_OP_WRITE) |=> ((drive_level_reg ^ $past(drive_level_reg)) & ~$past(wbits)) == '0;
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("unselected bit changed");

  property p_protect;
    @(posedge sys_clk_i) disable iff (srst_i)
      protect_reg |=> $stable(drive_level_reg);
  endproperty
  a_protect: assert property (p_protect) else $error("protected level changed");

  property p_out_level;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> (pin_o == (drive_level_reg & pin_oe_o));
  endproperty
  a_out_level: assert property (p_out_level) else $error("pin level mismatch");

  property p_pull;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> (pull_up_o | pull_down_o) == ($past(pull_enable_reg) & ~pin_oe_o) && (pull_up_o & pull_down_o) == '0;
  endproperty
  a_pull: assert property (p_pull) else $error("pull select wrong");

  property p_dir;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> pin_oe_o == $past(direction_reg);
  endproperty
  a_dir: assert property (p_dir) else $error("direction mismatch");

  property p_read_alias;
    @(posedge sys_clk_i) disable iff (srst_i)
      (s_axi_arvalid_i && s_axi_arready_o && is_level(s_axi_araddr_i))
        |=> s_axi_rvalid_o && s_axi_rdata_o == 32'($past(drive_level_reg));
  endproperty
  a_read_alias: assert property (p_read_alias) else $error("alias read wrong");

  sequence s_direct_write;
    level_hit && !protect_reg && op == DLV_OP_WRITE;
  endsequence

  property p_strobe_keep;
    @(posedge sys_clk_i) disable iff (srst_i)
      s_direct_write |=> ((drive_level_reg ^ $past(drive_level_reg)) & ~PINS'($past(wmask))) == '0;
  endproperty
  a_strobe_keep: assert property (p_strobe_keep) else $error("unstrobed level byte changed");

  sequence s_refused_write;
    wr.wr_en && protect_reg && is_level(wr.wr_addr);
  endsequence

  property p_refused_resp;
    @(posedge sys_clk_i) disable iff (srst_i)
      s_refused_write |=> s_axi_bvalid_o && s_axi_bresp_o == DLV_RESP_SLVERR;
  endproperty
  a_refused_resp: assert property (p_refused_resp) else $error("protected write not refused");

  property p_unmapped_keep;
    @(posedge sys_clk_i) disable iff (srst_i)
      (wr.wr_en && !is_mapped(wr.wr_addr))
        |=> $stable(drive_level_reg) && $stable(direction_reg) && $stable(pull_enable_reg);
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write changed state");

  property p_accept_resp;
    @(posedge sys_clk_i) disable iff (srst_i)
      (wr.wr_en && wr.wr_ok) |=> s_axi_bvalid_o && s_axi_bresp_o == DLV_RESP_OKAY;
  endproperty
  a_accept_resp: assert property (p_accept_resp) else $error("accepted write answer wrong");

  property p_oe_level;
    @(posedge sys_clk_i) disable iff (srst_i)
      (pin_o & ~pin_oe_o) == '0;
  endproperty
  a_oe_level: assert property (p_oe_level) else $error("undriven pin shows high");

  property p_bvalid_hold;
    @(posedge sys_clk_i) disable iff (srst_i)
      (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");

  property p_rvalid_hold;
    @(posedge sys_clk_i) disable iff (srst_i)
      (s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped");
endmodule // dlv_port_out

/* File: verif/testbench.sv */
// self-checking bench for the drive-level port block
`timescale 1ns/1ps
module testbench;
  import dlv_pkg::*;
  // ==========================================
  // clock, reset and bus signals
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, rdv, lvl, dir, pull;
  logic [7:0] offs [4];
  logic [1:0] k;
  logic [3:0] s;
  logic [31:0] d;
  int mismatches = 0, checked = 0, cyc = 0, seed = 70387;
  always #2.5 sys_clk_i = ~sys_clk_i;
  dlv_port_out #(.PINS(32)) dlv_port_out_i (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .pin_o(), .pin_oe_o(), .pull_up_o(), .pull_down_o()
  );
  // ==========================================
  // reporting
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc >= 20000) begin
      mismatches++;
      results();
    end
  end
  // ==========================================
  // bus master tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] ss);
    @(posedge sys_clk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dd;
    wstrb <= ss;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rdv = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // ==========================================
  // expectation functions
  function automatic logic [31:0] smask(input logic [3:0] st);
    for (int i = 0; i < 4; i++) smask[i*8 +: 8] = {8{st[i]}};
  endfunction
  function automatic logic [31:0] next_lvl(input logic [7:0] a, input logic [31:0] l, input logic [31:0] dv,
                                           input logic [3:0] st);
    logic [31:0] m;
    m = smask(st) & dv;
    case (a)
      DLV_CLEAR_OFFS: return l & ~m;
      DLV_SET_OFFS: return l | m;
      DLV_TOGGLE_OFFS: return l ^ m;
      default: return (l & ~smask(st)) | (dv & smask(st));
    endcase
  endfunction
  task automatic check_pins();
    chk(dlv_port_out_i.pin_o, lvl & dir);
    chk(dlv_port_out_i.pin_oe_o, dir);
    chk(dlv_port_out_i.pull_up_o, ~dir & pull & lvl);
    chk(dlv_port_out_i.pull_down_o, ~dir & pull & ~lvl);
  endtask
  // ==========================================
  // main sequence
  initial begin
    offs = '{DLV_DRIVE_LEVEL_OFFS, DLV_CLEAR_OFFS, DLV_SET_OFFS, DLV_TOGGLE_OFFS};
    lvl = DLV_DRIVE_LEVEL_RST;
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    dir = DLV_DIR_RST;
    pull = DLV_PULL_RST;
    check_pins();
    for (int i = 0; i < 4; i++) begin
      rd(offs[i]);
      chk(rdv, 32'h0000_0000);
    end
    dir = $random(seed);
    pull = $random(seed);
    wr(DLV_DIR_OFFS, dir, 4'hf);
    wr(DLV_PULL_OFFS, pull, 4'hf);
    for (int i = 0; i < 60; i++) begin
      k = 2'($random(seed));
      d = $random(seed);
      s = (i % 3 == 0) ? 4'($random(seed)) : 4'hf;
      if (i < 4) s = 4'hf;
      if (i == 0) {k, d} = {2'd2, 32'hffff_ffff};
      if (i == 1) {k, d} = {2'd1, 32'h0000_0000};
      if (i == 2) {k, d} = {2'd3, 32'hffff_ffff};
      if (i == 30) begin
        dir = ~dir;
        wr(DLV_DIR_OFFS, dir, 4'hf);
      end
      wr(offs[k], d, s);
      chk(32'(r), 32'(DLV_RESP_OKAY));
      lvl = next_lvl(offs[k], lvl, d, s);
      check_pins();
      k = 2'($random(seed));
      rd(offs[k]);
      chk(rdv, lvl);
    end
    wr(DLV_PROT_OFFS, 32'h0000_0001 << DLV_PROT_BIT, 4'hf);
    for (int i = 0; i < 4; i++) begin
      wr(offs[i], ~lvl, 4'hf);
      chk(32'(r), 32'(DLV_RESP_SLVERR));
      check_pins();
      rd(offs[i]);
      chk(rdv, lvl);
    end
    wr(DLV_PROT_OFFS, 32'h0000_0000, 4'hf);
    wr(DLV_TOGGLE_OFFS, 32'ha5a5_5a5a, 4'hf);
    lvl = lvl ^ 32'ha5a5_5a5a;
    check_pins();
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    lvl = DLV_DRIVE_LEVEL_RST;
    dir = DLV_DIR_RST;
    pull = DLV_PULL_RST;
    check_pins();
    rd(DLV_SET_OFFS);
    chk(rdv, lvl);
    wr(8'h30, 32'hffff_ffff, 4'hf);
    chk(32'(r), 32'(DLV_RESP_SLVERR));
    check_pins();
    rd(8'h30);
    chk(32'(r), 32'(DLV_RESP_SLVERR));
    chk(rdv, 32'h0000_0000);
    results();
  end
endmodule // testbench
